// ===== pkg/capture_pkg.sv
// Constants and mode encodings for the input capture channel.
package capture_pkg;
    localparam int TIMER_W     = 16;
    localparam int FIFO_DEPTH  = 4;
    localparam int PTR_W       = 2;
    localparam int CNT_W       = 3;
    localparam int NUM_CH      = 8;
    localparam int PRE_W       = 4;
    localparam logic [3:0] PRE_FOUR    = 4'h3;
    localparam logic [3:0] PRE_SIXTEEN = 4'hF;
    localparam logic [TIMER_W-1:0] CAP_RESET = 16'h0000;

    // Capture event mode select.
    typedef enum logic [2:0] {
        MODE_OFF     = 3'h0,
        MODE_FALL    = 3'h1,
        MODE_RISE    = 3'h2,
        MODE_BOTH    = 3'h3,
        MODE_RISE4   = 3'h4,
        MODE_RISE16  = 3'h5
    } cap_mode_e;
endpackage

// ===== rtl/input_capture_channel.sv
// Input capture channel with edge detection, prescaler and four-entry buffer.
`timescale 1ns/1ps
module input_capture_channel
    import capture_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               capture_input_pin,
    input  wire logic [2:0]         mode_sel,
    input  wire logic               time_base_sel,
    input  wire logic [TIMER_W-1:0] time_base_first,
    input  wire logic [TIMER_W-1:0] time_base_second,
    input  wire logic [1:0]         irq_level_sel,
    input  wire logic               low_power,
    input  wire logic               read_pulse,
    input  wire logic               overflow_clear,
    output logic [TIMER_W-1:0]      capture_value,
    output logic                    not_empty,
    output logic                    overflow,
    output logic                    irq,
    output logic                    wake
);
    logic                 sync1_r, sync2_r, prev_r;
    logic [PRE_W-1:0]     pre_r, pre_nxt;
    logic [TIMER_W-1:0]   mem_r [FIFO_DEPTH];
    logic [PTR_W-1:0]     wr_r, wr_nxt, rd_r, rd_nxt;
    logic [CNT_W-1:0]     cnt_r, cnt_nxt;
    logic                 ovf_r, ovf_nxt, irq_r, irq_nxt, wake_r, wake_nxt;
    logic                 ne_r, ne_nxt;
    logic [TIMER_W-1:0]   head_r, head_nxt;
    logic                 rise, fall, event_hit, push, pop;
    logic [TIMER_W-1:0]   base;
    cap_mode_e            mode;

    assign mode = cap_mode_e'(mode_sel);
    assign rise = sync2_r & ~prev_r;
    assign fall = ~sync2_r & prev_r;
    assign base = time_base_sel ? time_base_second : time_base_first;

    // The pin is asynchronous, so edges are judged only after two flops.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
        end else begin
            sync1_r <= capture_input_pin;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    always_comb begin
        pre_nxt   = pre_r;
        event_hit = 1'b0;
        // Simple modes clear the prescaler so every-4th counting restarts on mode entry.
        unique case (mode)
            MODE_FALL: begin
                pre_nxt   = '0;
                event_hit = fall;
            end
            MODE_RISE: begin
                pre_nxt   = '0;
                event_hit = rise;
            end
            MODE_BOTH: begin
                pre_nxt   = '0;
                event_hit = rise | fall;
            end
            MODE_RISE4: begin
                if (rise) begin
                    pre_nxt   = (pre_r >= PRE_FOUR) ? '0 : pre_r + 1'b1;
                    event_hit = (pre_r == PRE_FOUR);
                end
            end
            MODE_RISE16: begin
                if (rise) begin
                    pre_nxt   = pre_r + 1'b1;
                    event_hit = (pre_r == PRE_SIXTEEN);
                end
            end
            default: pre_nxt = '0;
        endcase
    end

    // A full buffer drops the new event instead of overwriting, so the oldest word survives.
    assign push = event_hit && (cnt_r != CNT_W'(FIFO_DEPTH));
    assign pop  = read_pulse && (cnt_r != '0);

    always_comb begin
        wr_nxt   = push ? wr_r + 1'b1 : wr_r;
        rd_nxt   = pop ? rd_r + 1'b1 : rd_r;
        cnt_nxt  = cnt_r + CNT_W'(push) - CNT_W'(pop);
        // A new overflow beats a clear in the same cycle.
        ovf_nxt  = (event_hit && cnt_r == CNT_W'(FIFO_DEPTH)) | (ovf_r & ~overflow_clear);
        irq_nxt  = cnt_nxt > CNT_W'(irq_level_sel);
        // Wake is a pulse, so a sleeping core sees one request per event.
        wake_nxt = low_power & event_hit;
        ne_nxt   = (cnt_nxt != '0);
        if (cnt_nxt == '0) begin
            head_nxt = CAP_RESET;
        end else if (cnt_r == '0 || (pop && cnt_r == 3'h1)) begin
            head_nxt = base;
        end else if (pop) begin
            head_nxt = mem_r[rd_r + 1'b1];
        end else begin
            head_nxt = mem_r[rd_r];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pre_r  <= '0;
            wr_r   <= '0;
            rd_r   <= '0;
            cnt_r  <= '0;
            ovf_r  <= 1'b0;
            irq_r  <= 1'b0;
            wake_r <= 1'b0;
            head_r <= CAP_RESET;
            ne_r   <= 1'b0;
        end else begin
            pre_r  <= pre_nxt;
            wr_r   <= wr_nxt;
            rd_r   <= rd_nxt;
            cnt_r  <= cnt_nxt;
            ovf_r  <= ovf_nxt;
            irq_r  <= irq_nxt;
            wake_r <= wake_nxt;
            head_r <= head_nxt;
            ne_r   <= ne_nxt;
        end
    end

    // Buffer storage carries no reset; the head register hides stale words.
    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wr_r] <= base;
        end
    end

    assign capture_value = head_r;
    assign not_empty     = ne_r;
    assign overflow      = ovf_r;
    assign irq           = irq_r;
    assign wake          = wake_r;

    // The flag is its own register, so this ties it back to the entry count.
    property not_empty_p;
        @(posedge clock) disable iff (rst) not_empty == (cnt_r != 3'h0);
    endproperty
    sequence rise_seen_s;
        mode == MODE_RISE && rise && cnt_r < 3'h4;
    endsequence
    sequence full_hit_s;
        event_hit && cnt_r == 3'h4;
    endsequence
    sequence second_push_s;
        push && cnt_r == 3'h0 && !pop && time_base_sel;
    endsequence

    rise_push_a: assert property (@(posedge clock) disable iff (rst)
        rise_seen_s |=> cnt_r == $past(cnt_r) + 3'h1 - 3'(($past(pop))))
        else $error("Rising edge not captured.");
    fall_push_a: assert property (@(posedge clock) disable iff (rst)
        mode == MODE_FALL && fall && cnt_r < 3'h4 |-> push)
        else $error("Falling edge not captured.");
    both_push_a: assert property (@(posedge clock) disable iff (rst)
        mode == MODE_BOTH && (rise || fall) |=> not_empty)
        else $error("Edge missed in both-edges mode.");
    pre_four_a: assert property (@(posedge clock) disable iff (rst)
        mode == MODE_RISE4 && event_hit |-> pre_r == 4'h3)
        else $error("Prescaler by four fired early.");
    first_value_a: assert property (@(posedge clock) disable iff (rst)
        push && cnt_r == 3'h0 && !pop |=> capture_value == $past(base))
        else $error("Captured value wrong.");
    irq_level_a: assert property (@(posedge clock) disable iff (rst)
        irq == (cnt_r > {1'b0, $past(irq_level_sel)}))
        else $error("Interrupt level mismatch.");
    wake_event_a: assert property (@(posedge clock) disable iff (rst)
        low_power && event_hit |=> wake)
        else $error("Wake not raised.");
    overflow_set_a: assert property (@(posedge clock) disable iff (rst)
        full_hit_s |=> overflow && cnt_r == 3'h4 - 3'($past(pop)))
        else $error("Overflow not flagged.");
    empty_flag_a: assert property (not_empty_p)
        else $error("Not-empty flag wrong.");
    base_second_a: assert property (@(posedge clock) disable iff (rst)
        second_push_s |=> capture_value == $past(time_base_second))
        else $error("Second time base not captured.");
    pre_sixteen_a: assert property (@(posedge clock) disable iff (rst)
        mode == MODE_RISE16 && event_hit |-> rise && pre_r == PRE_SIXTEEN)
        else $error("Prescaler by sixteen fired early.");
    wake_quiet_a: assert property (@(posedge clock) disable iff (rst)
        !low_power |=> !wake)
        else $error("Wake raised while awake.");
    empty_value_a: assert property (@(posedge clock) disable iff (rst)
        !not_empty |-> capture_value == CAP_RESET)
        else $error("Empty buffer shows a stale value.");
    overflow_hold_a: assert property (@(posedge clock) disable iff (rst)
        overflow && !overflow_clear |=> overflow)
        else $error("Overflow dropped without a clear.");
    overflow_clear_a: assert property (@(posedge clock) disable iff (rst)
        overflow_clear && !(event_hit && cnt_r == 3'h4) |=> !overflow)
        else $error("Overflow not cleared.");
    read_empty_a: assert property (@(posedge clock) disable iff (rst)
        read_pulse && cnt_r == 3'h0 && !event_hit |=> cnt_r == 3'h0)
        else $error("Read of an empty buffer changed the count.");
    fifo_bound_a: assert property (@(posedge clock) disable iff (rst)
        cnt_r <= 3'h4)
        else $error("Entry count above buffer depth.");
endmodule

// ===== bench/pin_source.sv
// Model of the external signal that drives the capture pin.
`timescale 1ns/1ps
module pin_source (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic toggle_req,
    output logic      pin
);
    // One level change per request, so every edge the bench asks for is a known event.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin <= 1'b0;
        end else if (toggle_req) begin
            pin <= ~pin;
        end
    end
endmodule

// ===== bench/input_capture_channel_test.sv
// Self-checking bench for the input capture channel.
`timescale 1ns/1ps
module input_capture_channel_test;
    import capture_pkg::*;
    logic        clock, rst, pin, tog, tsel, lp, rd, oclr, ne, ovf, irq, wake;
    logic [2:0]  mode;
    logic [1:0]  lvl;
    logic [15:0] tb0, tb1, val;
    int          fail_count, samples_checked, wakes;
    pin_source i_src (.clock(clock), .rst(rst), .toggle_req(tog), .pin(pin));
    input_capture_channel i_dut (.clock(clock), .rst(rst), .capture_input_pin(pin),
        .mode_sel(mode), .time_base_sel(tsel), .time_base_first(tb0),
        .time_base_second(tb1), .irq_level_sel(lvl), .low_power(lp), .read_pulse(rd),
        .overflow_clear(oclr), .capture_value(val), .not_empty(ne), .overflow(ovf),
        .irq(irq), .wake(wake));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) if (wake === 1'b1) wakes++;
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk_val(input string s, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_flag(input string s, input logic e, input logic g);
        chk_val(s, {15'h0000, e}, {15'h0000, g});
    endtask
    // Bases are held steady across the sync delay, so the expected capture is exact.
    task automatic flip(input logic [15:0] v);
        tb0 = v;
        tb1 = ~v;
        tog = 1'b1;
        tick(1);
        tog = 1'b0;
        tick(5);
    endtask
    task automatic pop();
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        tick(1);
    endtask
    task automatic prescale(input logic [2:0] m, input int n, input logic [15:0] b);
        mode = m;
        for (int i = 0; i < n; i++) begin
            flip(b + 16'(i));
            if (i == n - 2) chk_flag("prescale early", 1'b0, ne);
        end
        chk_val("prescale value", b + 16'(n - 1), val);
        pop();
        chk_flag("prescale single", 1'b0, ne);
    endtask
    task test_done();
        $display("Checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #50000;
        fail_count++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        lp = 1'b1;
        mode = MODE_RISE;
        {tog, tsel, rd, oclr, lvl, tb0, tb1} = '0;
        tick(6);
        rst = 1'b0;
        tick(1);
        flip(16'h1234);
        lp = 1'b0;
        flip(16'h5555);
        chk_val("capture", 16'h1234, val);
        chk_flag("irq", 1'b1, irq);
        chk_val("wake count", 16'h0001, 16'(wakes));
        pop();
        chk_flag("not empty", 1'b0, ne);
        mode = MODE_FALL;
        tsel = 1'b1;
        flip(16'h2222);
        flip(16'h3333);
        chk_val("fall capture", 16'hCCCC, val);
        pop();
        chk_flag("fall single", 1'b0, ne);
        mode = MODE_BOTH;
        tsel = 1'b0;
        lvl = 2'h3;
        for (int k = 0; k < 5; k++) begin
            if (k == 3) chk_flag("irq below level", 1'b0, irq);
            flip(16'hA000 + 16'(k));
        end
        chk_flag("overflow", 1'b1, ovf);
        chk_flag("irq at level", 1'b1, irq);
        for (int k = 0; k < 4; k++) begin
            chk_val("fifo order", 16'hA000 + 16'(k), val);
            pop();
        end
        chk_flag("drained", 1'b0, ne);
        chk_flag("irq drained", 1'b0, irq);
        oclr = 1'b1;
        tick(1);
        oclr = 1'b0;
        tick(1);
        chk_flag("overflow cleared", 1'b0, ovf);
        prescale(MODE_RISE4, 8, 16'hB000);
        mode = MODE_OFF;
        flip(16'hD000);
        flip(16'hD001);
        chk_flag("off mode", 1'b0, ne);
        prescale(MODE_RISE16, 32, 16'hC000);
        chk_val("wake total", 16'h0001, 16'(wakes));
        test_done();
    end
endmodule
